// ==== gsi_pkg.sv ====
// package: constants for the pad block and the status indicator
// assumes a 40 MHz system clock
package gsi_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int PAD_COUNT = 10;
   // pad modes
   localparam logic [1:0] MODE_INPUT = 2'h0;
   localparam logic [1:0] MODE_OUTPUT = 2'h1;
   localparam logic [1:0] MODE_ALT = 2'h2;
   localparam logic [1:0] MODE_RESET = MODE_INPUT;
   // blink timing in milliseconds
   localparam int FAST_PERIOD_MS = 1000;
   localparam int FAST_ON_MS = 500;
   localparam int SLOW_PERIOD_MS = 3000;
   localparam int SLOW_ON_MS = 300;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int FAST_PERIOD_CYC = FAST_PERIOD_MS * CYC_PER_MS;
   localparam int FAST_ON_CYC = FAST_ON_MS * CYC_PER_MS;
   localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CYC_PER_MS;
   localparam int SLOW_ON_CYC = SLOW_ON_MS * CYC_PER_MS;
   // network states seen by the indicator
   localparam logic [1:0] NET_OFF = 2'h0;
   localparam logic [1:0] NET_SEARCH = 2'h1;
   localparam logic [1:0] NET_REGISTERED = 2'h2;
   localparam logic [1:0] NET_CALL = 2'h3;
endpackage

// ==== gsi_pad.sv ====
// file: one configurable pad slice
// assumes pad_in is synchronous to clk and the pad has a pull-down outside
`timescale 1ns/1ps
module gsi_pad (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic out_level,
   input wire logic alt_level,
   input wire logic alt_oe,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic read_level
);
   logic next_pad_out;
   logic next_pad_oe;
   logic next_read_level;

   always_comb begin
      next_pad_out = 1'h0;
      next_pad_oe = 1'h0;
      next_read_level = pad_in;
      case (mode)
         gsi_pkg::MODE_OUTPUT: begin
            next_pad_out = out_level;
            next_pad_oe = 1'h1;
            next_read_level = out_level;
         end
         gsi_pkg::MODE_ALT: begin
            next_pad_out = alt_level;
            next_pad_oe = alt_oe;
            next_read_level = alt_oe ? alt_level : pad_in;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pad_out <= 1'h0;
         pad_oe <= 1'h0;
         read_level <= 1'h0;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
         read_level <= next_read_level;
      end
   end

   out_drives_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode == gsi_pkg::MODE_OUTPUT |=> pad_oe && pad_out == $past(out_level))
      else $error("output pad not driving its level");
   input_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode == gsi_pkg::MODE_INPUT |=> !pad_oe && read_level == $past(pad_in))
      else $error("input pad driving or misreading");
endmodule

// ==== gsi_gpio_status.sv ====
// file: ten-pad general-purpose port, temperature alarm and network status lamp
// assumes all inputs are synchronous to clk; pads have an external pull-down
`timescale 1ns/1ps
module gsi_gpio_status #(
   parameter int PADS = gsi_pkg::PAD_COUNT,
   parameter int FAST_PERIOD = gsi_pkg::FAST_PERIOD_CYC,
   parameter int FAST_ON = gsi_pkg::FAST_ON_CYC,
   parameter int SLOW_PERIOD = gsi_pkg::SLOW_PERIOD_CYC,
   parameter int SLOW_ON = gsi_pkg::SLOW_ON_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2*PADS-1:0] pad_mode,
   input wire logic [PADS-1:0] out_level,
   input wire logic [PADS-1:0] alt_level,
   input wire logic [PADS-1:0] alt_oe,
   input wire logic [PADS-1:0] pad_in,
   output logic [PADS-1:0] pad_out,
   output logic [PADS-1:0] pad_oe,
   output logic [PADS-1:0] read_level,
   input wire logic temp_alarm_enable,
   input wire logic [3:0] temp_alarm_pad,
   input wire logic temp_max_reached,
   input wire logic [1:0] net_state,
   output logic network_status_indicator
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   initial begin
      if (PADS < 1 || PADS > 16) $error("PADS must be 1..16");
      if (FAST_ON < 1 || FAST_ON >= FAST_PERIOD) $error("bad fast blink");
      if (SLOW_ON < 1 || SLOW_ON >= SLOW_PERIOD) $error("bad slow blink");
   end

   // ---------------------------------------------------------------
   // pads with temperature alarm override
   // ---------------------------------------------------------------
   logic [PADS-1:0] alarm_sel;
   logic [2*PADS-1:0] eff_mode;
   logic [PADS-1:0] eff_alt_level;
   logic [PADS-1:0] eff_alt_oe;

   always_comb begin
      eff_mode = pad_mode;
      eff_alt_level = alt_level;
      eff_alt_oe = alt_oe;
      for (int i = 0; i < PADS; i++) begin
         alarm_sel[i] = temp_alarm_enable && temp_alarm_pad == 4'(i);
         if (alarm_sel[i]) begin
            eff_mode[2*i +: 2] = gsi_pkg::MODE_ALT;
            eff_alt_level[i] = temp_max_reached;
            eff_alt_oe[i] = 1'h1;
         end
      end
   end

   // undriven inputs settle low through the pad pull-down outside
   for (genvar g = 0; g < PADS; g++) begin : g_pad
      gsi_pad u_pad (
         .clk(clk),
         .rst_n(rst_n),
         .mode(eff_mode[2*g +: 2]),
         .out_level(out_level[g]),
         .alt_level(eff_alt_level[g]),
         .alt_oe(eff_alt_oe[g]),
         .pad_in(pad_in[g]),
         .pad_out(pad_out[g]),
         .pad_oe(pad_oe[g]),
         .read_level(read_level[g])
      );
   end

   // ---------------------------------------------------------------
   // status lamp
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      LAMP_OFF = 4'h1,
      LAMP_FAST = 4'h2,
      LAMP_SLOW = 4'h4,
      LAMP_ON = 4'h8
   } gsi_lamp_e;

   localparam int CW = $clog2(SLOW_PERIOD > FAST_PERIOD ? SLOW_PERIOD : FAST_PERIOD) + 1;
   localparam logic [CW-1:0] FP = CW'(FAST_PERIOD - 1);
   localparam logic [CW-1:0] FO = CW'(FAST_ON);
   localparam logic [CW-1:0] SP = CW'(SLOW_PERIOD - 1);
   localparam logic [CW-1:0] SO = CW'(SLOW_ON);

   gsi_lamp_e lamp;
   gsi_lamp_e next_lamp;
   logic [CW-1:0] phase;
   logic [CW-1:0] next_phase;
   logic next_indicator;
   logic lit;

   always_comb begin
      case (net_state)
         gsi_pkg::NET_OFF: next_lamp = LAMP_OFF;
         gsi_pkg::NET_CALL: next_lamp = LAMP_ON;
         gsi_pkg::NET_REGISTERED: next_lamp = LAMP_SLOW;
         default: next_lamp = LAMP_FAST;
      endcase
      next_phase = '0;
      lit = 1'h0;
      if (next_lamp == lamp) begin
         case (lamp)
            LAMP_FAST: begin
               next_phase = (phase == FP) ? '0 : phase + CW'(1);
               lit = phase < FO;
            end
            LAMP_SLOW: begin
               next_phase = (phase == SP) ? '0 : phase + CW'(1);
               lit = phase < SO;
            end
            LAMP_ON: lit = 1'h1;
            default: lit = 1'h0;
         endcase
      end else begin
         // entry cycle already counts as phase 0
         next_phase = CW'(1);
         lit = next_lamp == LAMP_ON || next_lamp == LAMP_FAST || next_lamp == LAMP_SLOW;
      end
      next_indicator = ~lit;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lamp <= LAMP_OFF;
         phase <= '0;
         network_status_indicator <= 1'h1;
      end else begin
         lamp <= next_lamp;
         phase <= next_phase;
         network_status_indicator <= next_indicator;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // alarm pad
   alarm_drives_a: assert property (@(posedge clk) disable iff (!rst_n)
      temp_alarm_enable && temp_max_reached && 5'(temp_alarm_pad) < 5'(PADS) |=>
      pad_oe[$past(temp_alarm_pad)] && pad_out[$past(temp_alarm_pad)])
      else $error("alarm pad not driven high");
   alarm_waits_a: assert property (@(posedge clk) disable iff (!rst_n)
      temp_alarm_enable && !temp_max_reached && 5'(temp_alarm_pad) < 5'(PADS) |=>
      pad_oe[$past(temp_alarm_pad)] && !pad_out[$past(temp_alarm_pad)])
      else $error("alarm pad high before the limit");

   // pad modes
   alt_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
      pad_mode[1:0] == gsi_pkg::MODE_ALT && !alarm_sel[0] |=>
      pad_oe[0] == $past(alt_oe[0]))
      else $error("alt pad not following function");
   alt_reads_a: assert property (@(posedge clk) disable iff (!rst_n)
      pad_mode[2*PADS-1 -: 2] == gsi_pkg::MODE_ALT && !alarm_sel[PADS-1] && !alt_oe[PADS-1] |=>
      !pad_oe[PADS-1] && read_level[PADS-1] == $past(pad_in[PADS-1]))
      else $error("undriven alt pad misreading");
   out_query_a: assert property (@(posedge clk) disable iff (!rst_n)
      pad_mode[1:0] == gsi_pkg::MODE_OUTPUT && !alarm_sel[0] |=>
      read_level[0] == $past(out_level[0]))
      else $error("output query wrong");

   // status lamp
   lamp_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      net_state == gsi_pkg::NET_OFF |=> network_status_indicator)
      else $error("lamp lit while off");
   lamp_call_a: assert property (@(posedge clk) disable iff (!rst_n)
      net_state == gsi_pkg::NET_CALL |=> !network_status_indicator)
      else $error("lamp unlit during call");
   blink_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_OFF && net_state == gsi_pkg::NET_SEARCH |=> !network_status_indicator)
      else $error("fast blink did not start lit");
   fast_lit_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_FAST && net_state == gsi_pkg::NET_SEARCH && phase == '0 |=>
      !network_status_indicator)
      else $error("fast blink did not relight");
   fast_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_FAST && net_state == gsi_pkg::NET_SEARCH && phase == FO |=>
      network_status_indicator)
      else $error("fast blink lit too long");
   fast_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_FAST |-> phase <= FP)
      else $error("fast blink phase past its period");
   slow_lit_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_SLOW && net_state == gsi_pkg::NET_REGISTERED && phase == '0 |=>
      !network_status_indicator)
      else $error("slow blink did not relight");
   slow_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_SLOW && net_state == gsi_pkg::NET_REGISTERED && phase == SO |=>
      network_status_indicator)
      else $error("slow blink lit too long");
   slow_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      lamp == LAMP_SLOW |-> phase <= SP)
      else $error("slow blink phase past its period");

   // reset values
   reset_input_a: assert property (@(posedge clk)
      !rst_n |=> pad_oe == '0 && pad_out == '0 && read_level == '0)
      else $error("pad driving after reset");
   reset_lamp_a: assert property (@(posedge clk)
      !rst_n |=> network_status_indicator)
      else $error("lamp lit after reset");

   cover_fast_c: cover property (@(posedge clk) lamp == LAMP_FAST && phase == FP);
   cover_slow_c: cover property (@(posedge clk) lamp == LAMP_SLOW && phase == SP);
   cover_alarm_c: cover property (@(posedge clk) temp_alarm_enable && temp_max_reached);
   cover_call_c: cover property (@(posedge clk) lamp == LAMP_ON);
   cover_entry_c: cover property (@(posedge clk) lamp == LAMP_OFF && net_state == gsi_pkg::NET_SEARCH);
endmodule

// ==== gsi_far_side.sv ====
// file: model of the devices wired to the pads and of the lamp driver
// assumes pad_out/pad_oe come from the pad block and ext_* from the bench
`timescale 1ns/1ps
module gsi_far_side #(
   parameter int PADS = 10
) (
   input wire logic [PADS-1:0] pad_out,
   input wire logic [PADS-1:0] pad_oe,
   input wire logic [PADS-1:0] ext_level,
   input wire logic [PADS-1:0] ext_oe,
   input wire logic network_status_indicator,
   output logic [PADS-1:0] pad_in,
   output logic lamp_lit
);
   // pad wire: block first, then outside device, else the pull-down
   always_comb begin
      for (int i = 0; i < PADS; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_oe[i] ? ext_level[i] : 1'h0);
      end
   end
   // transistor stage inverts the pin
   assign lamp_lit = ~network_status_indicator;
endmodule

// ==== test_gsi_gpio_status.sv ====
// file: self-checking bench for the pad block and the status lamp
// assumes gsi_pkg, gsi_pad, gsi_gpio_status and gsi_far_side are compiled first
`timescale 1ns/1ps
module test_gsi_gpio_status;
   localparam int P = 10;
   localparam int FP = 10, FO = 5, SP = 30, SO = 3;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2*P-1:0] pad_mode = '0;
   logic [P-1:0] out_level = '0, alt_level = '0, alt_oe = '0, ext_level = '0, ext_oe = '0;
   logic [P-1:0] pad_in, pad_out, pad_oe, read_level;
   logic temp_alarm_enable = 1'b0, temp_max_reached = 1'b0;
   logic [3:0] temp_alarm_pad = 4'hF;
   logic [1:0] net_state = gsi_pkg::NET_OFF;
   logic network_status_indicator, lamp_lit;
   int num_errors = 0, checked = 0, cycles = 0;

   always #12.5 clk = ~clk;

   gsi_gpio_status #(.PADS(P), .FAST_PERIOD(FP), .FAST_ON(FO), .SLOW_PERIOD(SP), .SLOW_ON(SO)) i_dut (
      .clk(clk), .rst_n(rst_n), .pad_mode(pad_mode), .out_level(out_level), .alt_level(alt_level),
      .alt_oe(alt_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .read_level(read_level),
      .temp_alarm_enable(temp_alarm_enable), .temp_alarm_pad(temp_alarm_pad),
      .temp_max_reached(temp_max_reached), .net_state(net_state),
      .network_status_indicator(network_status_indicator)
   );
   gsi_far_side #(.PADS(P)) i_far (
      .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .ext_oe(ext_oe),
      .network_status_indicator(network_status_indicator), .pad_in(pad_in), .lamp_lit(lamp_lit)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("mismatches %0d, comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   // counts lit cycles over one period, then expects the relight
   task automatic blink(input logic [1:0] st, input int per, input int on);
      int lit;
      lit = 0;
      @(posedge clk);
      net_state <= gsi_pkg::NET_OFF;
      settle();
      @(posedge clk);
      net_state <= st;
      for (int i = 0; i < per; i++) begin
         settle();
         if (network_status_indicator === 1'b0) lit++;
      end
      check(lit, on);
      settle();
      check(network_status_indicator, 1'b0);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         num_errors++;
         complete_run();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      check({pad_oe, read_level}, '0);
      check(network_status_indicator, 1'h1);
      @(posedge clk);
      ext_oe <= '1;
      ext_level <= 10'h2A5;
      settle();
      check(pad_oe, '0);
      settle();
      check(read_level, 10'h2A5);
      @(posedge clk);
      ext_oe <= 10'h00F;
      settle();
      settle();
      check(read_level, 10'h005);
      @(posedge clk);
      ext_oe <= '0;
      pad_mode <= {P{gsi_pkg::MODE_OUTPUT}};
      out_level <= 10'h35A;
      settle();
      check({pad_oe, pad_out, read_level}, {10'h3FF, 10'h35A, 10'h35A});
      @(posedge clk);
      out_level <= 10'h0C3;
      settle();
      check({pad_out, read_level}, {10'h0C3, 10'h0C3});
      @(posedge clk);
      pad_mode <= {P{gsi_pkg::MODE_ALT}};
      alt_oe <= 10'h0FF;
      alt_level <= 10'h1F0;
      out_level <= '1;
      settle();
      check({pad_oe, pad_out & pad_oe, read_level}, {10'h0FF, 10'h0F0, 10'h0F0});
      @(posedge clk);
      pad_mode <= 20'h24924;
      alt_oe <= '1;
      alt_level <= '0;
      ext_oe <= '1;
      ext_level <= '1;
      settle();
      settle();
      check({pad_oe, pad_out & pad_oe, read_level}, {10'h1B6, 10'h092, 10'h2DB});
      @(posedge clk);
      temp_alarm_enable <= 1'b1;
      temp_alarm_pad <= 4'h3;
      temp_max_reached <= 1'b1;
      settle();
      check({pad_oe[3], pad_out[3]}, 2'h3);
      @(posedge clk);
      temp_max_reached <= 1'h0;
      settle();
      check({pad_oe[3], pad_out[3]}, 2'h2);
      @(posedge clk);
      temp_alarm_enable <= 1'h0;
      settle();
      check(pad_oe[3], 1'h0);
      @(posedge clk);
      temp_alarm_pad <= 4'hC;
      temp_alarm_enable <= 1'h1;
      temp_max_reached <= 1'h1;
      settle();
      check(pad_oe, 10'h1B6);
      check(pad_out & pad_oe, 10'h092);
      @(posedge clk);
      temp_alarm_enable <= 1'h0;
      repeat (20) @(posedge clk);
      #1;
      check(network_status_indicator, 1'b1);
      @(posedge clk);
      net_state <= gsi_pkg::NET_CALL;
      repeat (15) @(posedge clk);
      #1;
      check({network_status_indicator, lamp_lit}, 2'h1);
      blink(gsi_pkg::NET_SEARCH, FP, FO);
      blink(gsi_pkg::NET_REGISTERED, SP, SO);
      complete_run();
   end
endmodule
